// [src/pml_mod_limit.sv]
// APB-controlled duty modulation limiter with full-bridge split and pulse skipping
// Functional notes
// - Full-bridge splits modulation across two outputs
// - Full-bridge halves both upper and lower bounds
// - Three-bit field selects upper modulation bound
// - Two-bit field selects lower bound floor
// - Enable bit makes sub-floor demand skip pulses
`timescale 1ns/1ps
module pml_mod_limit (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [11:0]                     paddr,
    input  wire logic [31:0]                     pwdata,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    output logic signed [pml_pkg::MOD_W-1:0]     mod_a,
    output logic signed [pml_pkg::MOD_W-1:0]     mod_b,
    output logic                                 skip_pulse,
    output logic                                 full_bridge
);
    logic        [7:0]                 cfg_r, cfg_nxt;
    logic signed [pml_pkg::MOD_W-1:0] req_r, req_nxt;
    logic signed [pml_pkg::MOD_W-1:0] a_r, a_nxt, b_r, b_nxt;
    logic                              skip_r, skip_nxt;
    logic        [31:0]                rd_r, rd_nxt;
    logic                              err_r, err_nxt;
    logic signed [pml_pkg::MOD_W-1:0] hi_lim, lo_lim, dem_a, dem_b;
    logic                              wr_acc, rd_acc, hit;

    pml_limit_calc u_calc (
        .cfg    (cfg_r),
        .hi_lim (hi_lim),
        .lo_lim (lo_lim)
    );

    // Access decode; zero wait states
    assign wr_acc  = psel & penable & pwrite;
    assign rd_acc  = psel & penable & ~pwrite;
    assign hit     = (paddr == pml_pkg::ADDR_CFG) || (paddr == pml_pkg::ADDR_DUTY_REQ)
                     || (paddr == pml_pkg::ADDR_STATUS);
    assign pready  = 1'b1;
    assign pslverr = err_r;
    assign prdata  = rd_r;

    // Register writes and read data capture
    always_comb begin
        cfg_nxt  = cfg_r;
        req_nxt  = req_r;
        rd_nxt   = rd_r;
        err_nxt  = 1'b0;
        if (psel && !penable) begin
            err_nxt = ~hit;
            case (paddr)
                pml_pkg::ADDR_CFG:      rd_nxt = {24'h000000, cfg_r};
                pml_pkg::ADDR_DUTY_REQ: rd_nxt = {{(32-pml_pkg::MOD_W){req_r[pml_pkg::MOD_W-1]}},
                                                  req_r};
                pml_pkg::ADDR_STATUS:   rd_nxt = {7'h00, skip_r, a_r, b_r};
                default:                rd_nxt = 32'h00000000;
            endcase
        end
        if (wr_acc && paddr == pml_pkg::ADDR_CFG) begin
            cfg_nxt = pwdata[7:0] & pml_pkg::CFG_WMASK;
        end
        if (wr_acc && paddr == pml_pkg::ADDR_DUTY_REQ) begin
            req_nxt = signed'(pwdata[pml_pkg::MOD_W-1:0]);
        end
    end

    // Bus registers; a read is captured in the setup cycle so that prdata
    // stands through the whole access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= pml_pkg::CFG_RESET;
            req_r <= '0;
            rd_r  <= 32'h00000000;
            err_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            req_r <= req_nxt;
            rd_r  <= rd_nxt;
            err_r <= err_nxt;
        end
    end

    // Split the demand into per-output shares, bound each and decide on skipping
    always_comb begin
        if (cfg_r[pml_pkg::FB_BIT]) begin
            dem_a = req_r >>> 1;
            dem_b = req_r - dem_a;
        end else begin
            dem_a = req_r;
            dem_b = '0;
        end
        // The smaller share decides, so no output is held below the floor
        skip_nxt = cfg_r[pml_pkg::SKIP_BIT] && (dem_a < lo_lim);
        // Output A carries modulation in both modes
        if (dem_a > hi_lim) begin
            a_nxt = hi_lim;
        end else if (dem_a < lo_lim) begin
            a_nxt = lo_lim;
        end else begin
            a_nxt = dem_a;
        end
        // Output B carries modulation only in full bridge, under the halved bounds
        if (!cfg_r[pml_pkg::FB_BIT]) begin
            b_nxt = '0;
        end else if (dem_b > hi_lim) begin
            b_nxt = hi_lim;
        end else if (dem_b < lo_lim) begin
            b_nxt = lo_lim;
        end else begin
            b_nxt = dem_b;
        end
        // Skipped pulses leave both outputs at nominal
        if (skip_nxt) begin
            a_nxt = '0;
            b_nxt = '0;
        end
    end

    // Output registers follow cfg_r and req_r one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_r    <= '0;
            b_r    <= '0;
            skip_r <= 1'b0;
        end else begin
            a_r    <= a_nxt;
            b_r    <= b_nxt;
            skip_r <= skip_nxt;
        end
    end

    assign mod_a       = a_r;
    assign mod_b       = b_r;
    assign skip_pulse  = skip_r;
    assign full_bridge = cfg_r[pml_pkg::FB_BIT];

    // Reserved configuration bit never holds a one
    a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_r[3] == 1'b0) else $error("Reserved config bit is set");

    // A write with the reserved bit set leaves it clear
    a_rsvd_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == pml_pkg::ADDR_CFG && pwdata[3]) |=> cfg_r[3] == 1'b0)
        else $error("Reserved bit took a write");

    // A config read shows zero in the reserved bit and above the byte
    a_rsvd_read: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_acc && paddr == pml_pkg::ADDR_CFG) |-> prdata[31:8] == 24'h000000 && !prdata[3])
        else $error("Reserved bit read back set");

    // Enabled skipping with a share below the floor blanks both outputs
    a_skip_on: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_r[pml_pkg::SKIP_BIT]
         && (cfg_r[pml_pkg::FB_BIT] ? (req_r >>> 1) : req_r) < lo_lim)
        |=> skip_pulse && mod_a == 0 && mod_b == 0) else $error("Pulse skip missing");

    // Without the enable, pulses are never skipped
    a_skip_off: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_r[pml_pkg::SKIP_BIT] |=> !skip_pulse) else $error("Skip while disabled");

    // With the enable, a single-output demand at or above the floor keeps its pulses
    a_skip_floor: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_r[pml_pkg::SKIP_BIT] && !cfg_r[pml_pkg::FB_BIT] && req_r >= lo_lim)
        |=> !skip_pulse) else $error("Skip above the floor");

    // In full bridge the two shares differ by one step at most
    a_split_even: assert property (@(posedge pclk) disable iff (!presetn)
        (full_bridge && $past(cfg_r[pml_pkg::FB_BIT]) && !skip_pulse)
        |-> (mod_a - mod_b) inside {-1, 0}) else $error("Uneven split");

    // In single-output mode the second output stays at nominal
    a_single_out: assert property (@(posedge pclk) disable iff (!presetn)
        (!$past(cfg_r[pml_pkg::FB_BIT])) |-> mod_b == 0) else $error("Second output used");

    // Code 7 on one output caps at 50 % of the period, 512 steps
    a_hi_bound: assert property (@(posedge pclk) disable iff (!presetn)
        (!cfg_r[7] && cfg_r[6:4] == 3'h7 && req_r > 12'sh200) |=> mod_a == 12'sh200)
        else $error("High clamp wrong");

    // Code 0 on one output caps at 12.5 % of the period, 128 steps
    a_hi_code0: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_r[7:0] == 8'h00 && req_r > 12'sh080) |=> mod_a == 12'sh080)
        else $error("Lowest high clamp wrong");

    // Code 3 on one output floors at 43.75 % below nominal, 448 steps
    a_lo_bound: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_r[7:0] == 8'h03 && req_r < -12'sh1c0) |=> mod_a == -12'sh1c0)
        else $error("Low clamp wrong");

    // Code 0 on one output floors at 50 % below nominal, 512 steps
    a_lo_code0: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_r[7:0] == 8'h00 && req_r < -12'sh200) |=> mod_a == -12'sh200)
        else $error("Widest low clamp wrong");

    // Full bridge halves both bounds of the selected codes
    a_fb_half: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_r[7] |-> hi_lim == signed'(pml_pkg::HI_TAB[cfg_r[6:4]] >> 1)
                  && lo_lim == -signed'(pml_pkg::LO_TAB[cfg_r[1:0]] >> 1))
        else $error("Full-bridge limits not halved");

    // Full bridge code 7 caps each output at 25 % of the period, 256 steps
    a_fb_hi_cap: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_r[7:0] == 8'hf0 && req_r > 12'sh200)
        |=> mod_a == 12'sh100 && mod_b == 12'sh100) else $error("Full-bridge high clamp wrong");

    // Full bridge code 0 floors each output at 25 % below nominal, 256 steps
    a_fb_lo_cap: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_r[7:0] == 8'h80 && req_r < -12'sh200)
        |=> mod_a == -12'sh100 && mod_b == -12'sh100) else $error("Full-bridge low clamp wrong");

    // Outputs never pass the widest bounds: 50 % on A, 25 % on B
    a_range_cap: assert property (@(posedge pclk) disable iff (!presetn)
        mod_a <= 12'sh200 && mod_a >= -12'sh200 && mod_b <= 12'sh100 && mod_b >= -12'sh100)
        else $error("Output beyond widest bound");
endmodule : pml_mod_limit

// [src/pml_pkg.sv]
// Package with register map, field layout and limit tables for the modulation limiter
package pml_pkg;
    // Register map (byte addresses on APB)
    localparam logic [11:0] ADDR_CFG       = 12'h000;  // modulation_limit_config
    localparam logic [11:0] ADDR_DUTY_REQ  = 12'h004;  // Requested modulation, signed
    localparam logic [11:0] ADDR_STATUS    = 12'h008;  // Applied state, read only
    localparam logic [7:0]  CFG_RESET      = 8'h00;
    localparam logic [7:0]  CFG_WMASK      = 8'hf7;    // Bit 3 reserved
    // Field positions
    localparam int FB_BIT    = 7;
    localparam int HI_MSB    = 6;
    localparam int HI_LSB    = 4;
    localparam int SKIP_BIT  = 2;
    localparam int LO_MSB    = 1;
    localparam int LO_LSB    = 0;
    // Modulation is a signed offset from nominal in 1/1024 of the switching period
    localparam int MOD_W = 12;
    // High limits, single output: 12.5,25,31.25,37.5,43.75,46.88,48.44,50 %
    localparam logic [MOD_W-1:0] HI_TAB [8] = '{
        12'h080, 12'h100, 12'h140, 12'h180, 12'h1c0, 12'h1e0, 12'h1f0, 12'h200};
    // Low limits, single output: 50,48.44,46.88,43.75 % below nominal
    localparam logic [MOD_W-1:0] LO_TAB [4] = '{12'h200, 12'h1f0, 12'h1e0, 12'h1c0};
    localparam logic [11:0] PSLVERR_NONE = 12'h000;
endpackage : pml_pkg

// [src/pml_limit_calc.sv]
// Combinational lookup of the applied upper and lower bounds
`timescale 1ns/1ps
module pml_limit_calc (
    input  wire logic [7:0]              cfg,
    output logic signed [pml_pkg::MOD_W-1:0] hi_lim,
    output logic signed [pml_pkg::MOD_W-1:0] lo_lim
);
    logic [pml_pkg::MOD_W-1:0] hi_base;
    logic [pml_pkg::MOD_W-1:0] lo_base;
    // Table lookup, halved in full-bridge mode
    always_comb begin
        hi_base = pml_pkg::HI_TAB[cfg[pml_pkg::HI_MSB:pml_pkg::HI_LSB]];
        lo_base = pml_pkg::LO_TAB[cfg[pml_pkg::LO_MSB:pml_pkg::LO_LSB]];
        if (cfg[pml_pkg::FB_BIT]) begin
            hi_base = hi_base >> 1;
            lo_base = lo_base >> 1;
        end
        hi_lim = signed'(hi_base);
        lo_lim = -signed'(lo_base);
    end
endmodule : pml_limit_calc

// [testbench/pml_mod_limit_tb.sv]
// Self-checking bench for the APB-configured modulation limiter
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module pml_mod_limit_tb;
    logic                        pclk = 1'b0;
    logic                        presetn, psel, penable, pwrite;
    logic                        pready, pslverr, skip_pulse, full_bridge, err;
    logic [11:0]                 paddr, hv, lv;
    logic [31:0]                 pwdata, prdata, rd;
    logic signed [11:0]          mod_a, mod_b;
    int                          error_cnt = 0;
    int                          tests_run = 0;

    pml_mod_limit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mod_a(mod_a), .mod_b(mod_b), .skip_pulse(skip_pulse),
        .full_bridge(full_bridge));

    // 100 MHz clock
    always #5 pclk = ~pclk;

    // Prints the counts and the verdict, then ends the run
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    // One APB transfer; read data and error are taken at the pready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Writes config and request, then lets the outputs settle
    task automatic setup(input logic [31:0] cfg, input logic [31:0] req);
        apb(1'b1, pml_pkg::ADDR_CFG, cfg);
        apb(1'b1, pml_pkg::ADDR_DUTY_REQ, req);
        repeat (3) @(posedge pclk);
    endtask : setup

    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        `CHK({full_bridge, skip_pulse, mod_a, mod_b}, 26'h0)
        apb(1'b0, pml_pkg::ADDR_CFG, 32'h0);
        `CHK(rd, 32'h0000_0000)
        `CHK(err, 1'b0)
        apb(1'b1, pml_pkg::ADDR_CFG, 32'h0000_00ff);
        apb(1'b0, pml_pkg::ADDR_CFG, 32'h0);
        `CHK(rd, 32'h0000_00f7)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0000_0000)
        apb(1'b1, 12'h00c, 32'h0000_0000);
        `CHK(err, 1'b1)
        apb(1'b0, pml_pkg::ADDR_CFG, 32'h0);
        `CHK(rd, 32'h0000_00f7)
        // Every upper-bound code, single output then full bridge
        for (int c = 0; c < 8; c++) begin
            hv = pml_pkg::HI_TAB[c];
            setup(32'(c << 4), 32'h0000_07ff);
            `CHK(mod_a, hv)
            `CHK(mod_b, 12'h000)
            setup(32'h80 | 32'(c << 4), 32'h0000_07ff);
            `CHK(full_bridge, 1'b1)
            `CHK(mod_a, hv >> 1)
            `CHK(mod_b, hv - (hv >> 1))
            apb(1'b0, pml_pkg::ADDR_STATUS, 32'h0);
            `CHK(rd, {8'h00, hv >> 1, hv - (hv >> 1)})
        end
        // Every lower-bound code, with and without skipping, and at the floor itself
        for (int c = 0; c < 4; c++) begin
            lv = 12'h000 - pml_pkg::LO_TAB[c];
            setup(32'(c), 32'hffff_f800);
            apb(1'b0, pml_pkg::ADDR_DUTY_REQ, 32'h0);
            `CHK(rd, 32'hffff_f800)
            `CHK(mod_a, lv)
            `CHK(skip_pulse, 1'b0)
            setup(32'(c) | 32'h04, 32'hffff_f800);
            `CHK(skip_pulse, 1'b1)
            `CHK(mod_a, 12'h000)
            setup(32'(c) | 32'h04, {{20{lv[11]}}, lv});
            `CHK(skip_pulse, 1'b0)
            `CHK(mod_a, lv)
            setup(32'h80 | 32'(c), 32'hffff_f800);
            `CHK(mod_a, $signed(lv) >>> 1)
            `CHK(mod_b, $signed(lv) >>> 1)
            setup(32'h84 | 32'(c), 32'hffff_f800);
            `CHK(skip_pulse, 1'b1)
            `CHK({mod_a, mod_b}, 24'h000000)
        end
        // A reset in mid-run returns every register and output to zero
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK({full_bridge, skip_pulse, mod_a, mod_b}, 26'h0)
        presetn <= 1'b1;
        apb(1'b0, pml_pkg::ADDR_CFG, 32'h0);
        `CHK(rd, 32'h0000_0000)
        report_and_stop();
    end
endmodule : pml_mod_limit_tb
